// *** verilog/synth_cal_defines.svh ***
// What this block does
// - Control bit 13 enables lock detector; resets to 1
// - Bits 8:7 pick high compare frequency adjustment; default 0
// - Bits 6:5 pick low compare frequency adjustment; default 0
// - Bit 4 set lets amplitude calibration run; clear stops it
// - Every write of 1 to bit 3 starts frequency calibration
// - Bit 2 picks monitor pin: lock status or register readback
// - Writing 1 to bit 1 resets device; bit clears itself
// - Bit 0 powers the whole device down; resets to 0
// - Calibration clock is reference input over two to the exponent
// - Bits 15:8 of register at address 4 hold amplitude calibration settle delay, default 25
// - Amplitude override blocks amplitude calibration, manual value used
`ifndef SYNTH_CAL_DEFINES_SVH
`define SYNTH_CAL_DEFINES_SVH

`define FRAME_BITS 5'h18
`define HEADER_LAST_BIT 5'h07
`define FRAME_LAST_BIT 5'h17
`define FRAME_RW_BIT 23
`define HEADER_RW_BIT 7

`define MAIN_CONTROL_ADDR 7'h00
`define CAL_CLOCK_DIVIDE_ADDR 7'h01
`define FIXED_SETTING_TWO_ADDR 7'h02
`define AMP_CAL_DELAY_ADDR 7'h04
`define FIXED_SETTING_SEVEN_ADDR 7'h07

`define MAIN_CONTROL_RESET 16'h201c
`define CAL_CLOCK_DIVIDE_RESET 16'h0000
`define FIXED_SETTING_TWO_RESET 16'h0000
`define AMP_CAL_DELAY_RESET 16'h1900
`define FIXED_SETTING_SEVEN_RESET 16'h0000

`define BIT_LOCK_DETECT_ENABLE 13
`define FIELD_HIGH_ADJUST 8:7
`define FIELD_LOW_ADJUST 6:5
`define BIT_AMPLITUDE_CAL_ENABLE 4
`define BIT_FREQUENCY_CAL_ENABLE 3
`define BIT_MONITOR_PIN_SELECT 2
`define BIT_SOFT_RESET 1
`define BIT_POWER_DOWN 0
`define FIELD_CAL_EXPONENT 2:0
`define FIELD_SETTLE_DELAY 15:8

`endif

// *** verilog/synth_cal_pkg.sv ***
package synth_cal_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [6:0] reg_addr_t;
    typedef logic [2:0] cal_exponent_t;
endpackage

// *** verilog/serial_frame_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface serial_frame_if;
    logic write_strobe;
    logic read_strobe;
    synth_cal_pkg::reg_addr_t address;
    synth_cal_pkg::reg_word_t write_data;
    synth_cal_pkg::reg_word_t read_data;
    logic readback_bit;
    modport shifter (
        output write_strobe, read_strobe, address, write_data, readback_bit,
        input read_data
    );
    modport regs (
        input write_strobe, read_strobe, address, write_data, readback_bit,
        output read_data
    );
endinterface
`default_nettype wire

// *** verilog/serial_frame_shifter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "synth_cal_defines.svh"
module serial_frame_shifter (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_serial_clock,
    input wire logic i_serial_data,
    input wire logic i_serial_select_n,
    serial_frame_if.shifter frame
);
    logic serial_clock_q;
    logic [23:0] shift_in;
    logic [4:0] bit_count;
    logic read_frame;
    synth_cal_pkg::reg_addr_t address;
    synth_cal_pkg::reg_word_t shift_out;
    logic write_strobe;
    logic read_strobe;

    wire rise = i_serial_clock && !serial_clock_q && !i_serial_select_n;
    wire [23:0] next_shift_in = {shift_in[22:0], i_serial_data};
    wire header_done = rise && (bit_count == `HEADER_LAST_BIT);
    wire frame_done = rise && (bit_count == `FRAME_LAST_BIT);
    // Readback shifts after each data rise so the host sees the MSB first
    wire data_phase = rise && read_frame && (bit_count > `HEADER_LAST_BIT);

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            serial_clock_q <= 1'b0;
            shift_in <= 24'h000000;
            bit_count <= 5'h00;
            read_frame <= 1'b0;
            address <= 7'h00;
            shift_out <= 16'h0000;
            write_strobe <= 1'b0;
            read_strobe <= 1'b0;
        end else begin
            serial_clock_q <= i_serial_clock;
            write_strobe <= frame_done && !next_shift_in[`FRAME_RW_BIT];
            read_strobe <= header_done && next_shift_in[`HEADER_RW_BIT];
            if (i_serial_select_n) begin
                bit_count <= 5'h00;
            end else if (rise) begin
                shift_in <= next_shift_in;
                bit_count <= frame_done ? 5'h00 : bit_count + 5'h01;
            end
            if (header_done) begin
                address <= next_shift_in[6:0];
                read_frame <= next_shift_in[`HEADER_RW_BIT];
            end
            if (read_strobe) begin
                shift_out <= frame.read_data;
            end else if (data_phase) begin
                shift_out <= {shift_out[14:0], 1'b0};
            end
        end
    end

    assign frame.write_strobe = write_strobe;
    assign frame.read_strobe = read_strobe;
    assign frame.address = address;
    assign frame.write_data = shift_in[15:0];
    assign frame.readback_bit = shift_out[15];
endmodule
`default_nettype wire

// *** verilog/synth_cal_control_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "synth_cal_defines.svh"
module synth_cal_control_regs (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_serial_clock,
    input wire logic i_serial_data,
    input wire logic i_serial_select_n,
    input wire logic i_reference_input,
    input wire logic i_lock_status,
    input wire logic i_amplitude_override,
    input wire logic [9:0] i_amplitude_manual_value,
    output logic o_monitor_pin,
    output logic o_lock_detect_enable,
    output logic [1:0] o_freqcal_high_compare_adjust,
    output logic [1:0] o_freqcal_low_compare_adjust,
    output logic o_amplitude_cal_run,
    output logic [9:0] o_amplitude_drive_value,
    output logic o_frequency_cal_enable,
    output logic o_freqcal_start,
    output logic o_device_reset,
    output logic o_power_down,
    output logic o_cal_clock,
    output logic [7:0] o_amplitude_cal_settle_delay
);
    serial_frame_if frame ();

    serial_frame_shifter shifter (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_serial_clock(i_serial_clock),
        .i_serial_data(i_serial_data),
        .i_serial_select_n(i_serial_select_n),
        .frame(frame.shifter)
    );

    function automatic logic hits(input synth_cal_pkg::reg_addr_t addr,
                                  input synth_cal_pkg::reg_addr_t target);
        hits = (addr == target);
    endfunction

    synth_cal_pkg::reg_word_t main_control;
    synth_cal_pkg::reg_word_t cal_clock_divide;
    synth_cal_pkg::reg_word_t fixed_setting_two;
    synth_cal_pkg::reg_word_t amp_cal_delay;
    synth_cal_pkg::reg_word_t fixed_setting_seven;
    logic reference_q;
    logic [6:0] reference_count;

    wire [6:0] addr = frame.address;
    wire [15:0] data = frame.write_data;
    wire wr_main = frame.write_strobe && hits(addr, `MAIN_CONTROL_ADDR);
    wire wr_divide = frame.write_strobe && hits(addr, `CAL_CLOCK_DIVIDE_ADDR);
    wire wr_two = frame.write_strobe && hits(addr, `FIXED_SETTING_TWO_ADDR);
    wire wr_delay = frame.write_strobe && hits(addr, `AMP_CAL_DELAY_ADDR);
    wire wr_seven = frame.write_strobe
        && hits(addr, `FIXED_SETTING_SEVEN_ADDR);
    wire soft_reset_hit = wr_main && data[`BIT_SOFT_RESET];
    wire freqcal_trigger = (wr_main && data[`BIT_FREQUENCY_CAL_ENABLE])
        || soft_reset_hit;
    wire [2:0] exponent = cal_clock_divide[`FIELD_CAL_EXPONENT];
    wire reference_rise = i_reference_input && !reference_q;
    wire next_cal_clock = (exponent == 3'h0) ? reference_q
        : reference_count[3'(exponent - 3'h1)];
    wire acal_allowed = main_control[`BIT_AMPLITUDE_CAL_ENABLE]
        && !i_amplitude_override;
    wire lock_shown = i_lock_status && main_control[`BIT_LOCK_DETECT_ENABLE];
    wire next_monitor = main_control[`BIT_MONITOR_PIN_SELECT] ? lock_shown
        : frame.readback_bit;

    // Unmapped addresses read back as zero
    assign frame.read_data =
        hits(addr, `MAIN_CONTROL_ADDR) ? main_control :
        hits(addr, `CAL_CLOCK_DIVIDE_ADDR) ? cal_clock_divide :
        hits(addr, `FIXED_SETTING_TWO_ADDR) ? fixed_setting_two :
        hits(addr, `AMP_CAL_DELAY_ADDR) ? amp_cal_delay :
        hits(addr, `FIXED_SETTING_SEVEN_ADDR) ? fixed_setting_seven :
        16'h0000;

    // Soft reset is taken as a whole-group reset, so the same frame's
    // other bits are discarded
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || soft_reset_hit) begin
            main_control <= `MAIN_CONTROL_RESET;
            cal_clock_divide <= `CAL_CLOCK_DIVIDE_RESET;
            fixed_setting_two <= `FIXED_SETTING_TWO_RESET;
            amp_cal_delay <= `AMP_CAL_DELAY_RESET;
            fixed_setting_seven <= `FIXED_SETTING_SEVEN_RESET;
        end else begin
            if (wr_main) begin
                main_control <= data;
            end
            if (wr_divide) begin
                cal_clock_divide <= data;
            end
            if (wr_two) begin
                fixed_setting_two <= data;
            end
            if (wr_delay) begin
                amp_cal_delay <= data;
            end
            if (wr_seven) begin
                fixed_setting_seven <= data;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            reference_q <= 1'b0;
            reference_count <= 7'h00;
            o_cal_clock <= 1'b0;
        end else begin
            reference_q <= i_reference_input;
            if (reference_rise) begin
                reference_count <= reference_count + 7'h01;
            end
            o_cal_clock <= next_cal_clock;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_monitor_pin <= 1'b0;
            o_lock_detect_enable <= 1'b0;
            o_freqcal_high_compare_adjust <= 2'h0;
            o_freqcal_low_compare_adjust <= 2'h0;
            o_amplitude_cal_run <= 1'b0;
            o_amplitude_drive_value <= 10'h000;
            o_frequency_cal_enable <= 1'b0;
            o_freqcal_start <= 1'b0;
            o_device_reset <= 1'b0;
            o_power_down <= 1'b0;
            o_amplitude_cal_settle_delay <= 8'h00;
        end else begin
            o_monitor_pin <= next_monitor;
            o_lock_detect_enable <= main_control[`BIT_LOCK_DETECT_ENABLE];
            o_freqcal_high_compare_adjust <= main_control[`FIELD_HIGH_ADJUST];
            o_freqcal_low_compare_adjust <= main_control[`FIELD_LOW_ADJUST];
            o_amplitude_cal_run <= acal_allowed;
            o_amplitude_drive_value <= i_amplitude_manual_value;
            o_frequency_cal_enable <= main_control[`BIT_FREQUENCY_CAL_ENABLE];
            o_freqcal_start <= freqcal_trigger;
            o_device_reset <= soft_reset_hit;
            o_power_down <= main_control[`BIT_POWER_DOWN];
            o_amplitude_cal_settle_delay <= amp_cal_delay[`FIELD_SETTLE_DELAY];
        end
    end

    a_lock_enable_write: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        (wr_main && !data[`BIT_SOFT_RESET])
        |=> ##1 o_lock_detect_enable
            == $past(data[`BIT_LOCK_DETECT_ENABLE], 2))
        else $error("lock detect enable does not follow write");
    a_high_adjust_write: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        (wr_main && !data[`BIT_SOFT_RESET])
        |=> ##1 o_freqcal_high_compare_adjust
            == $past(data[`FIELD_HIGH_ADJUST], 2))
        else $error("high adjust does not follow write");
    a_low_adjust_write: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        (wr_main && !data[`BIT_SOFT_RESET])
        |=> ##1 o_freqcal_low_compare_adjust
            == $past(data[`FIELD_LOW_ADJUST], 2))
        else $error("low adjust does not follow write");
    a_acal_disabled: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        !main_control[`BIT_AMPLITUDE_CAL_ENABLE] |=> !o_amplitude_cal_run)
        else $error("amplitude calibration runs while disabled");
    a_freqcal_start_pulse: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        (wr_main && data[`BIT_FREQUENCY_CAL_ENABLE])
        |=> o_freqcal_start ##1 !o_freqcal_start)
        else $error("frequency calibration start missing");
    a_monitor_lock_show: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        (main_control[`BIT_MONITOR_PIN_SELECT]
            && main_control[`BIT_LOCK_DETECT_ENABLE])
        |=> o_monitor_pin == $past(i_lock_status))
        else $error("monitor pin does not show lock");
    a_soft_reset_self: assert property (
        @(posedge i_clock) disable iff (!i_reset_n) soft_reset_hit
        |=> main_control == `MAIN_CONTROL_RESET && o_device_reset
        ##1 !o_device_reset)
        else $error("soft reset does not restore or self clear");
    a_power_down_write: assert property (
        @(posedge i_clock) disable iff (!i_reset_n)
        (wr_main && !data[`BIT_SOFT_RESET])
        |=> ##1 o_power_down == $past(data[`BIT_POWER_DOWN], 2))
        else $error("power down does not follow write");
    a_cal_clock_undivided: assert property (
        @(posedge i_clock) disable iff (!i_reset_n) (exponent == 3'h0)
        |=> o_cal_clock == $past(reference_q))
        else $error("undivided calibration clock wrong");
    a_settle_delay_out: assert property (
        @(posedge i_clock) disable iff (!i_reset_n) wr_delay
        |=> ##1 o_amplitude_cal_settle_delay
            == $past(data[`FIELD_SETTLE_DELAY], 2))
        else $error("settle delay does not follow write");
    a_override_blocks: assert property (
        @(posedge i_clock) disable iff (!i_reset_n) i_amplitude_override
        |=> !o_amplitude_cal_run)
        else $error("amplitude calibration runs under override");
    a_soft_reset_group: assert property (
        @(posedge i_clock) disable iff (!i_reset_n) soft_reset_hit
        |=> amp_cal_delay == `AMP_CAL_DELAY_RESET
        && cal_clock_divide == `CAL_CLOCK_DIVIDE_RESET
        && o_freqcal_start)
        else $error("soft reset leaves fields or calibration");
endmodule
`default_nettype wire

// *** testbench/synth_cal_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module synth_cal_host (
    input wire logic i_clock,
    input wire logic i_monitor_pin,
    output logic o_serial_clock,
    output logic o_serial_data,
    output logic o_serial_select_n,
    output logic o_read_valid,
    output synth_cal_pkg::reg_word_t o_read_word
);
    int hold = 3;
    initial begin
        o_serial_clock = 1'b0;
        o_serial_data = 1'b0;
        o_serial_select_n = 1'b1;
        o_read_valid = 1'b0;
        o_read_word = 16'h0000;
    end
    // Serial clock idles low between frames; three cycles per phase minimum
    task automatic frame(input logic rw, input synth_cal_pkg::reg_addr_t addr,
                         input synth_cal_pkg::reg_word_t data);
        logic [23:0] bits;
        bits = {rw, addr, data};
        @(posedge i_clock);
        #1 o_serial_select_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            o_serial_data = bits[i];
            repeat (hold) @(posedge i_clock);
            #1;
            if (rw && i < 16) o_read_word[i] = i_monitor_pin;
            o_serial_clock = 1'b1;
            repeat (hold) @(posedge i_clock);
            #1 o_serial_clock = 1'b0;
        end
        // Released data line must not keep showing the last bit
        o_serial_data = ~o_serial_data;
        o_serial_select_n = 1'b1;
        o_read_valid = rw;
        @(posedge i_clock);
        #1 o_read_valid = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/synth_cal_control_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module synth_cal_control_regs_tb_top;
    logic i_clock = 1'b0, i_reset_n = 1'b0, ref_in = 1'b0, lock = 1'b1;
    logic ovr = 1'b0, sck, sdi, ssn, rd_valid, prev_cal = 1'b0;
    logic [9:0] man = 10'h12c;
    logic mon, lde, acr, fce, fst, drs, pwd, cal;
    logic [1:0] hadj, ladj;
    logic [9:0] drv;
    logic [7:0] dly;
    synth_cal_pkg::reg_word_t rd_word, w, exp_q[$];
    logic [31:0] lfsr = 32'hc809;
    int fail_count = 0, n_compared = 0, n_start = 0, n_rst = 0, n_cal = 0;
    int c0, c1;
    logic [6:0] addrs[5] = '{7'h01, 7'h02, 7'h04, 7'h07, 7'h03};
    initial forever #4 i_clock = ~i_clock;
    initial forever begin
        repeat (2) @(posedge i_clock);
        #1 ref_in = ~ref_in;
    end
    synth_cal_control_regs dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_serial_clock(sck), .i_serial_data(sdi), .i_serial_select_n(ssn),
        .i_reference_input(ref_in), .i_lock_status(lock),
        .i_amplitude_override(ovr), .i_amplitude_manual_value(man),
        .o_monitor_pin(mon), .o_lock_detect_enable(lde),
        .o_freqcal_high_compare_adjust(hadj),
        .o_freqcal_low_compare_adjust(ladj), .o_amplitude_cal_run(acr),
        .o_amplitude_drive_value(drv), .o_frequency_cal_enable(fce),
        .o_freqcal_start(fst), .o_device_reset(drs), .o_power_down(pwd),
        .o_cal_clock(cal), .o_amplitude_cal_settle_delay(dly));
    synth_cal_host host (.i_clock(i_clock), .i_monitor_pin(mon),
        .o_serial_clock(sck), .o_serial_data(sdi), .o_serial_select_n(ssn),
        .o_read_valid(rd_valid), .o_read_word(rd_word));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] expected);
        n_compared++;
        if (seen !== expected) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, expected, seen);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.frame(1'b0, a, d);
        repeat (2) @(posedge i_clock);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.frame(1'b1, a, 16'h0000);
    endtask
    // Result watcher: readback words, pulse and clock-edge counts
    always @(posedge i_clock) begin
        prev_cal <= cal;
        if (cal === 1'b1 && prev_cal === 1'b0) n_cal++;
        if (fst === 1'b1) n_start++;
        if (drs === 1'b1) n_rst++;
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected read", 16'h1, 16'h0);
            else check("readback", rd_word, exp_q.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge i_clock);
        check("watchdog", 16'h1, 16'h0);
        test_done();
    end
    initial begin
        repeat (12) @(posedge i_clock);
        #1 i_reset_n = 1'b1;
        repeat (3) @(posedge i_clock);
        #1;
        check("lock_en", 16'(lde), 16'h1);
        check("adjust", 16'({hadj, ladj}), 16'h0);
        check("acal_run", 16'(acr), 16'h1);
        check("frequency_cal_enable", 16'(fce), 16'h1);
        check("monitor lock", 16'(mon), 16'h1);
        check("power_down", 16'(pwd), 16'h0);
        check("settle", 16'(dly), 16'h0019);
        lock = 1'b0;
        repeat (3) @(posedge i_clock);
        #1 check("monitor unlock", 16'(mon), 16'h0);
        for (int i = 0; i < 4; i++) begin
            c0 = n_start;
            // Unnamed bits written as zero defaults
            w = 16'h2010 | 16'(i << 7) | 16'((3 - i) << 5)
                | 16'((i % 2) << 3);
            wr(7'h00, w);
            check("high adj", 16'(hadj), 16'(i));
            check("low adj", 16'(ladj), 16'(3 - i));
            check("frequency_cal_enable", 16'(fce), 16'(i % 2));
            check("fcal start", 16'(n_start - c0), 16'(i % 2));
        end
        rd(7'h00, w);
        rd(7'h01, 16'h0000);
        rd(7'h04, 16'h1900);
        host.hold = 6;
        foreach (addrs[k]) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr[15:0];
            // Unnamed ranges keep their zero defaults
            if (addrs[k] == 7'h01) w = w & 16'h0007;
            if (addrs[k] == 7'h02 || addrs[k] == 7'h07) w = 16'h0000;
            // Settle delay kept at 25 or more for a safe compare window
            if (addrs[k] == 7'h04) w = {w[15:8] | 8'h19, 8'h00};
            wr(addrs[k], w);
            if (addrs[k] == 7'h04)
                check("settle", 16'(dly), 16'(w[15:8]));
            rd(addrs[k], (addrs[k] == 7'h03) ? 16'h0000 : w);
        end
        host.hold = 3;
        ovr = 1'b1;
        lfsr = lfsr_next(lfsr);
        #8 man = 10'd250 + 10'(lfsr[7:0] % 200);
        repeat (3) @(posedge i_clock);
        #1 check("acal blocked", 16'(acr), 16'h0);
        check("manual value", 16'(drv), 16'(man));
        ovr = 1'b0;
        wr(7'h00, 16'h2000);
        check("acal disabled", 16'(acr), 16'h0);
        for (int k = 0; k < 8; k++) begin
            wr(7'h01, 16'(k));
            repeat (8) @(posedge i_clock);
            c1 = n_cal;
            repeat (128 << k) @(posedge i_clock);
            c1 = n_cal - c1;
            check("cal clock", 16'(c1 >= 31 && c1 <= 33), 16'h1);
        end
        wr(7'h00, 16'h2001);
        check("power_down", 16'(pwd), 16'h1);
        c0 = n_start;
        c1 = n_rst;
        lock = 1'b1;
        wr(7'h00, 16'h2003);
        check("reset pulse", 16'(n_rst - c1), 16'h1);
        check("restart", 16'(n_start - c0), 16'h1);
        check("power up", 16'(pwd), 16'h0);
        check("settle", 16'(dly), 16'h0019);
        check("lock_en", 16'(lde), 16'h1);
        check("monitor lock", 16'(mon), 16'h1);
        wr(7'h00, 16'h2010);
        rd(7'h00, 16'h2010);
        rd(7'h01, 16'h0000);
        rd(7'h04, 16'h1900);
        repeat (2) @(posedge i_clock);
        check("pending reads", 16'(exp_q.size()), 16'h0);
        test_done();
    end
endmodule
`default_nettype wire
